// ### hdl/stu_pkg.sv
// Shared constants and types for the software trap unit
package stu_pkg;

  // Fixed low-memory locations
  localparam logic [23:0] QUEUE_PTR_ADDR  = 24'h00_0080;
  localparam logic [23:0] QS_PSW_ADDR     = 24'h00_0088;
  localparam logic [23:0] FAULT_PSW_ADDR  = 24'h00_0048;
  localparam logic [23:0] SVC_PSW_ADDR    = 24'h00_0098;
  localparam logic [23:0] SVC_TABLE_ADDR  = 24'h00_009C;
  localparam logic [23:0] WORD_STEP       = 24'h00_0004;
  localparam logic [23:0] QCOUNT_OFFSET   = 24'h00_0000;

  // Status doubleword bit positions, bit 0 being the most significant
  localparam int PSW_WAIT_BIT    = 63 - 16;
  localparam int PSW_LVLA_BIT    = 63 - 17;
  localparam int PSW_UFMASK_BIT  = 63 - 19;
  localparam int PSW_LVLB_BIT    = 63 - 20;
  localparam int PSW_QSEN_BIT    = 63 - 22;
  localparam int PSW_PROT_BIT    = 63 - 23;
  localparam int HI_SET_LSB      = 36 - 32;
  localparam int SET_W           = 4;
  localparam int LEVELS          = 4;

  // Register numbers within a set
  localparam logic [3:0] REG_R12 = 4'hC;
  localparam logic [3:0] REG_R13 = 4'hD;
  localparam logic [3:0] REG_R14 = 4'hE;
  localparam logic [3:0] REG_R15 = 4'hF;

  // Arithmetic fault reason codes
  localparam logic [2:0] CODE_FIX_DIV0  = 3'h0;
  localparam logic [2:0] CODE_FIX_OVF   = 3'h1;
  localparam logic [2:0] CODE_FLT_DIV0  = 3'h2;
  localparam logic [2:0] CODE_FLT_UNDER = 3'h3;
  localparam logic [2:0] CODE_FLT_OVER  = 3'h4;

  // Trap sequencer states
  typedef enum logic [10:0] {
    ST_IDLE   = 11'h001,
    ST_QPTR   = 11'h002,
    ST_QCOUNT = 11'h004,
    ST_PSW_HI = 11'h008,
    ST_PSW_LO = 11'h010,
    ST_TABLE  = 11'h020,
    ST_WR14   = 11'h040,
    ST_WR15   = 11'h080,
    ST_WR13   = 11'h100,
    ST_WR12   = 11'h200,
    ST_LOAD   = 11'h400
  } stu_state_t;

  // Kind of trap being sequenced
  typedef enum logic [2:0] {
    KIND_QS    = 3'h1,
    KIND_SVC   = 3'h2,
    KIND_FAULT = 3'h4
  } stu_kind_t;

endpackage

// ### hdl/stu_level_enable.sv
// I/O interrupt level enable decode from status bits and register set
`timescale 1ns/1ns
module stu_level_enable (
  input  wire logic [3:0] regSet,
  input  wire logic       lvlBitA,
  input  wire logic       lvlBitB,
  input  wire logic       simulated,
  output logic [3:0]      levelEnable
);

  // One decode per level; a simulated request enables every level
  genvar lvl;
  generate
    for (lvl = 0; lvl < stu_pkg::LEVELS; lvl++) begin : g_level
      assign levelEnable[lvl] = simulated | (lvlBitA && !lvlBitB)  // see RULE1
                                | (lvlBitA && lvlBitB && regSet >= 4'(lvl))
                                | (!lvlBitA && lvlBitB && regSet > 4'(lvl));
    end
  endgenerate

endmodule // stu_level_enable

// ### hdl/stu_fault_classify.sv
// Arithmetic fault detection, underflow masking and reason code
`timescale 1ns/1ns
module stu_fault_classify (
  input  wire logic       fixedDivZero,
  input  wire logic       fixedOverflow,
  input  wire logic       floatDivZero,
  input  wire logic       floatOverflow,
  input  wire logic       floatUnderflow,
  input  wire logic       underflowMask,
  output logic            raiseFault,
  output logic            forceZero,
  output logic [2:0]      reasonCode
);

  // Overflow and divide by zero always fault; underflow only when unmasked
  always_comb begin
    raiseFault = fixedDivZero | fixedOverflow | floatDivZero | floatOverflow;  // see RULE17
    forceZero  = 1'b0;
    reasonCode = stu_pkg::CODE_FIX_DIV0;
    if (floatUnderflow && underflowMask) begin
      raiseFault = 1'b1;  // see RULE18
    end else if (floatUnderflow) begin
      forceZero  = ~raiseFault;  // see RULE18
    end
    // Reason code, fixed point before floating point, divide by zero first in each
    if (fixedDivZero) begin
      reasonCode = stu_pkg::CODE_FIX_DIV0;  // see RULE21
    end else if (fixedOverflow) begin
      reasonCode = stu_pkg::CODE_FIX_OVF;
    end else if (floatDivZero) begin
      reasonCode = stu_pkg::CODE_FLT_DIV0;
    end else if (floatOverflow) begin
      reasonCode = stu_pkg::CODE_FLT_OVER;
    end else if (floatUnderflow) begin
      reasonCode = stu_pkg::CODE_FLT_UNDER;
    end
  end

endmodule // stu_fault_classify

// ### hdl/stu_trap_unit.sv
// Software trap and arithmetic fault sequencer
`timescale 1ns/1ns
// Summary of operation
// RULE1 - simulated interrupt treats all levels enabled
// RULE2 - simulated interrupt never acknowledges real requests
// RULE3 - status load tests queue enable bit
// RULE4 - enabled: read queue pointer, test count
// RULE5 - nonempty queue: save status, R13 queue, switch
// RULE6 - exchange saves next address, others loaded counter
// RULE7 - queue additions alone never trap
// RULE8 - software keeps queue aligned, never overfull
// RULE9 - call saves status in R14/R15 new set
// RULE10 - call loads R13 with operand address
// RULE11 - call switches status, counter from table
// RULE12 - call saves counter of next instruction
// RULE13 - supervisor call trap is never masked
// RULE14 - breakpoint enters console unless protect set
// RULE15 - breakpoint alters nothing, counter stays put
// RULE16 - console exit clears wait bit
// RULE17 - overflow and divide by zero always fault
// RULE18 - masked underflow gives zero, else fault
// RULE19 - faulting instruction aborted before any write
// RULE20 - fault saves status in R14/R15 new set
// RULE21 - fault loads R13 with reason code
// RULE22 - table entry at base plus doubled field
// RULE23 - fault loads R12 with next address
// RULE24 - fault saves counter of faulting instruction
// RULE25 - upper status half into lower register
module stu_trap_unit (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        statusLoaded,
  input  wire logic        loadWasExchange,
  input  wire logic        svcExec,
  input  wire logic [3:0]  svcField,
  input  wire logic [23:0] operandAddr,
  input  wire logic        brkExec,
  input  wire logic        sintExec,
  input  wire logic [9:0]  sintDevice,
  input  wire logic [3:0]  sintSet,
  input  wire logic        consoleRun,
  input  wire logic        arithDone,
  input  wire logic        fixedDivZero,
  input  wire logic        fixedOverflow,
  input  wire logic        floatDivZero,
  input  wire logic        floatOverflow,
  input  wire logic        floatUnderflow,
  input  wire logic [63:0] currentPsw,
  input  wire logic [31:0] nextInstrAddr,
  input  wire logic [31:0] memRdData,
  input  wire logic        memRdValid,
  output logic             memRdReq,
  output logic [23:0]      memAddr,
  output logic             regWrEn,
  output logic [3:0]       regWrSet,
  output logic [3:0]       regWrNum,
  output logic [31:0]      regWrData,
  output logic             pswLoad,
  output logic [63:0]      pswNew,
  output logic             busy,
  output logic             consoleMode,
  output logic             privFault,
  output logic             abortInstr,
  output logic             zeroResult,
  output logic             sintStart,
  output logic [9:0]       sintDeviceOut,
  output logic [3:0]       sintSetOut,
  output logic             realAckEnable,
  output logic [3:0]       levelEnable
);

  stu_pkg::stu_state_t state_ff;
  stu_pkg::stu_state_t nxt_state;
  stu_pkg::stu_kind_t  kind_ff;
  logic [31:0]         saveHi_ff;
  logic [31:0]         saveLo_ff;
  logic [31:0]         r13Val_ff;
  logic [31:0]         r12Val_ff;
  logic [31:0]         newHi_ff;
  logic [31:0]         newLo_ff;
  logic [23:0]         tableAddr_ff;
  logic [23:0]         queueAddr_ff;
  logic                memRdReq_ff;
  logic [23:0]         memAddr_ff;
  logic                regWrEn_ff;
  logic [3:0]          regWrNum_ff;
  logic [31:0]         regWrData_ff;
  logic                pswLoad_ff;
  logic [63:0]         pswNew_ff;
  logic                consoleMode_ff;
  logic                privFault_ff;
  logic                abortInstr_ff;
  logic                zeroResult_ff;
  logic                sintStart_ff;
  logic [9:0]          sintDevice_ff;
  logic [3:0]          sintSet_ff;
  logic                realAck_ff;
  logic                busy_ff;
  logic [3:0]          levelEnable_ff;
  logic                faultRaise;
  logic                faultZero;
  logic [2:0]          faultCode;
  logic [3:0]          levelDecode;
  logic                idle;
  logic                protect;
  logic                takeFault;
  logic                takeSvc;
  logic                takeQs;
  logic                takeSint;
  logic [15:0]         tableHalf;

  assign idle      = (state_ff == stu_pkg::ST_IDLE);
  assign protect   = currentPsw[stu_pkg::PSW_PROT_BIT];
  // Fault, call and queue traps one at a time, fault first; simulated interrupt not held off; requests while busy are ignored
  assign takeFault = idle && arithDone && faultRaise;
  assign takeSvc   = idle && !takeFault && svcExec;  // see RULE13
  assign takeQs    = idle && !takeFault && !svcExec && statusLoaded
                     && currentPsw[stu_pkg::PSW_QSEN_BIT];  // see RULE3, RULE7
  assign takeSint  = idle && sintExec && !protect;
  // Big-endian halfword pick from the fetched table word
  assign tableHalf = tableAddr_ff[1] ? memRdData[15:0] : memRdData[31:16];    // see RULE22

  stu_fault_classify u_fault (
    .fixedDivZero  (fixedDivZero),
    .fixedOverflow (fixedOverflow),
    .floatDivZero  (floatDivZero),
    .floatOverflow (floatOverflow),
    .floatUnderflow(floatUnderflow),
    .underflowMask (currentPsw[stu_pkg::PSW_UFMASK_BIT]),
    .raiseFault    (faultRaise),
    .forceZero     (faultZero),
    .reasonCode    (faultCode)
  );

  stu_level_enable u_level (
    .regSet     (currentPsw[stu_pkg::HI_SET_LSB + 32 +: stu_pkg::SET_W]),
    .lvlBitA    (currentPsw[stu_pkg::PSW_LVLA_BIT]),
    .lvlBitB    (currentPsw[stu_pkg::PSW_LVLB_BIT]),
    .simulated  (takeSint),
    .levelEnable(levelDecode)
  );

  // Next state of the trap sequencer
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      stu_pkg::ST_IDLE: begin
        if (takeFault || takeSvc) begin
          nxt_state = stu_pkg::ST_PSW_HI;
        end else if (takeQs) begin
          nxt_state = stu_pkg::ST_QPTR;  // see RULE4
        end
      end
      stu_pkg::ST_QPTR: nxt_state = memRdValid ? stu_pkg::ST_QCOUNT : state_ff;
      stu_pkg::ST_QCOUNT: begin
        if (memRdValid) begin
          nxt_state = (memRdData[15:0] == 16'h0000) ? stu_pkg::ST_IDLE      // see RULE4
                                                     : stu_pkg::ST_PSW_HI;
        end
      end
      stu_pkg::ST_PSW_HI: begin
        if (memRdValid) begin
          nxt_state = (kind_ff == stu_pkg::KIND_SVC) ? stu_pkg::ST_TABLE
                                                      : stu_pkg::ST_PSW_LO;
        end
      end
      stu_pkg::ST_PSW_LO, stu_pkg::ST_TABLE: nxt_state = memRdValid ? stu_pkg::ST_WR14 : state_ff;
      stu_pkg::ST_WR14: nxt_state = stu_pkg::ST_WR15;
      stu_pkg::ST_WR15: nxt_state = stu_pkg::ST_WR13;
      stu_pkg::ST_WR13: begin
        nxt_state = (kind_ff == stu_pkg::KIND_FAULT) ? stu_pkg::ST_WR12 : stu_pkg::ST_LOAD;
      end
      stu_pkg::ST_WR12: nxt_state = stu_pkg::ST_LOAD;
      stu_pkg::ST_LOAD: nxt_state = stu_pkg::ST_IDLE;
      default:          nxt_state = stu_pkg::ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clock) begin
    if (reset) begin
      state_ff <= stu_pkg::ST_IDLE;
      busy_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      busy_ff  <= (nxt_state != stu_pkg::ST_IDLE);
    end
  end

  // Capture of old status, R13 and R12 contents at trap entry
  always_ff @(posedge clock) begin
    if (reset) begin
      kind_ff      <= stu_pkg::KIND_QS;
      saveHi_ff    <= 32'h0000_0000;
      saveLo_ff    <= 32'h0000_0000;
      r13Val_ff    <= 32'h0000_0000;
      r12Val_ff    <= 32'h0000_0000;
      tableAddr_ff <= 24'h00_0000;
    end else if (takeFault) begin
      kind_ff   <= stu_pkg::KIND_FAULT;
      saveHi_ff <= currentPsw[63:32];
      saveLo_ff <= currentPsw[31:0];  // see RULE24
      r13Val_ff <= {29'h0000_0000, faultCode};  // see RULE21
      r12Val_ff <= nextInstrAddr;  // see RULE23
    end else if (takeSvc) begin
      kind_ff      <= stu_pkg::KIND_SVC;
      saveHi_ff    <= currentPsw[63:32];
      saveLo_ff    <= nextInstrAddr;  // see RULE12
      r13Val_ff    <= {8'h00, operandAddr};  // see RULE10
      tableAddr_ff <= stu_pkg::SVC_TABLE_ADDR + {19'h0_0000, svcField, 1'b0};  // see RULE22
    end else if (takeQs) begin
      kind_ff   <= stu_pkg::KIND_QS;
      saveHi_ff <= currentPsw[63:32];
      saveLo_ff <= loadWasExchange ? nextInstrAddr : currentPsw[31:0];  // see RULE6
    end else if (state_ff == stu_pkg::ST_QCOUNT && memRdValid) begin
      r13Val_ff <= {8'h00, queueAddr_ff};  // see RULE5
    end
  end

  // New status words and queue pointer fetched from memory
  always_ff @(posedge clock) begin
    if (reset) begin
      newHi_ff     <= 32'h0000_0000;
      newLo_ff     <= 32'h0000_0000;
      queueAddr_ff <= 24'h00_0000;
    end else if (memRdValid) begin
      case (state_ff)
        stu_pkg::ST_QPTR:   queueAddr_ff <= memRdData[23:0];
        stu_pkg::ST_PSW_HI: newHi_ff     <= memRdData;  // see RULE9
        stu_pkg::ST_PSW_LO: newLo_ff     <= memRdData;
        stu_pkg::ST_TABLE:  newLo_ff     <= {16'h0000, tableHalf};  // see RULE11
        default: ;
      endcase
    end
  end

  // Memory read port: request held until the word is returned
  always_ff @(posedge clock) begin
    if (reset) begin
      memRdReq_ff <= 1'b0;
      memAddr_ff  <= 24'h00_0000;
    end else if (takeFault) begin
      memRdReq_ff <= 1'b1;
      memAddr_ff  <= stu_pkg::FAULT_PSW_ADDR;  // see RULE20
    end else if (takeSvc) begin
      memRdReq_ff <= 1'b1;
      memAddr_ff  <= stu_pkg::SVC_PSW_ADDR;  // see RULE9
    end else if (takeQs) begin
      memRdReq_ff <= 1'b1;
      memAddr_ff  <= stu_pkg::QUEUE_PTR_ADDR;  // see RULE4
    end else if (memRdValid && memRdReq_ff) begin
      unique case (state_ff)
        stu_pkg::ST_QPTR: memAddr_ff <= memRdData[23:0] + stu_pkg::QCOUNT_OFFSET;
        stu_pkg::ST_QCOUNT: begin
          memRdReq_ff <= (memRdData[15:0] != 16'h0000);
          memAddr_ff  <= stu_pkg::QS_PSW_ADDR;  // see RULE5
        end
        stu_pkg::ST_PSW_HI: begin
          memAddr_ff <= (kind_ff == stu_pkg::KIND_SVC) ? {tableAddr_ff[23:2], 2'b00}
                                                        : memAddr_ff + stu_pkg::WORD_STEP;
        end
        default: begin
          memRdReq_ff <= 1'b0;
        end
      endcase
    end
  end

  // Register set write port, one write per cycle into the new set
  always_ff @(posedge clock) begin
    if (reset) begin
      regWrEn_ff   <= 1'b0;
      regWrNum_ff  <= stu_pkg::REG_R12;
      regWrData_ff <= 32'h0000_0000;
    end else begin
      regWrEn_ff <= state_ff inside {stu_pkg::ST_WR14, stu_pkg::ST_WR15, stu_pkg::ST_WR13, stu_pkg::ST_WR12};
      unique case (state_ff)
        stu_pkg::ST_WR14: begin
          regWrNum_ff  <= stu_pkg::REG_R14;
          regWrData_ff <= saveHi_ff;  // see RULE25
        end
        stu_pkg::ST_WR15: begin
          regWrNum_ff  <= stu_pkg::REG_R15;
          regWrData_ff <= saveLo_ff;  // see RULE25
        end
        stu_pkg::ST_WR13: begin
          regWrNum_ff  <= stu_pkg::REG_R13;
          regWrData_ff <= r13Val_ff;
        end
        stu_pkg::ST_WR12: begin
          regWrNum_ff  <= stu_pkg::REG_R12;
          regWrData_ff <= r12Val_ff;
        end
        default: ;
      endcase
    end
  end

  // Status load: trap new status, or console exit with wait cleared
  always_ff @(posedge clock) begin
    if (reset) begin
      pswLoad_ff <= 1'b0;
      pswNew_ff  <= 64'h0000_0000_0000_0000;
    end else if (state_ff == stu_pkg::ST_LOAD) begin
      pswLoad_ff <= 1'b1;
      pswNew_ff  <= {newHi_ff, newLo_ff};  // see RULE5
    end else if (idle && consoleRun && consoleMode_ff) begin
      pswLoad_ff <= 1'b1;
      pswNew_ff  <= currentPsw & ~(64'h1 << stu_pkg::PSW_WAIT_BIT);  // see RULE16
    end else begin
      pswLoad_ff <= 1'b0;
    end
  end

  // Console mode: entered by an unprotected breakpoint, left on run
  always_ff @(posedge clock) begin
    if (reset) begin
      consoleMode_ff <= 1'b0;
    end else if (idle && brkExec && !protect) begin
      consoleMode_ff <= 1'b1;  // see RULE14, RULE15
    end else if (idle && consoleRun) begin
      consoleMode_ff <= 1'b0;
    end
  end

  // Single-cycle indications to the execution unit
  always_ff @(posedge clock) begin
    if (reset) begin
      privFault_ff  <= 1'b0;
      abortInstr_ff <= 1'b0;
      zeroResult_ff <= 1'b0;
    end else begin
      privFault_ff  <= idle && (brkExec || sintExec) && protect;  // see RULE14
      abortInstr_ff <= takeFault;  // see RULE19
      zeroResult_ff <= idle && arithDone && faultZero && !faultRaise;  // see RULE18
    end
  end

  // Simulated interrupt hand-off into the normal I/O sequence
  always_ff @(posedge clock) begin
    if (reset) begin
      sintStart_ff   <= 1'b0;
      sintDevice_ff  <= 10'h000;
      sintSet_ff     <= 4'h0;
      realAck_ff     <= 1'b0;
      levelEnable_ff <= 4'h0;
    end else begin
      sintStart_ff   <= takeSint;
      realAck_ff     <= !takeSint;  // see RULE2
      levelEnable_ff <= levelDecode;  // see RULE1
      if (takeSint) begin
        sintDevice_ff <= sintDevice;
        sintSet_ff    <= sintSet;
      end
    end
  end

  assign memRdReq      = memRdReq_ff;
  assign memAddr       = memAddr_ff;
  assign regWrEn       = regWrEn_ff;
  assign regWrSet      = newHi_ff[stu_pkg::HI_SET_LSB +: stu_pkg::SET_W];
  assign regWrNum      = regWrNum_ff;
  assign regWrData     = regWrData_ff;
  assign pswLoad       = pswLoad_ff;
  assign pswNew        = pswNew_ff;
  assign busy          = busy_ff;
  assign consoleMode   = consoleMode_ff;
  assign privFault     = privFault_ff;
  assign abortInstr    = abortInstr_ff;
  assign zeroResult    = zeroResult_ff;
  assign sintStart     = sintStart_ff;
  assign sintDeviceOut = sintDevice_ff;
  assign sintSetOut    = sintSet_ff;
  assign realAckEnable = realAck_ff;
  assign levelEnable   = levelEnable_ff;

endmodule // stu_trap_unit

// ### test/stu_mem_model.sv
// Behavioural main memory that answers the trap unit reads
`timescale 1ns/1ns
module stu_mem_model (
  input  wire logic        clock,
  input  wire logic        slow,
  input  wire logic [15:0] qCount,
  input  wire logic        memRdReq,
  input  wire logic [23:0] memAddr,
  output logic      [31:0] memRdData,
  output logic             memRdValid
);
  logic [1:0] waitCnt = 2'h0;
  // Low memory image; the queue pointer is kept fullword aligned
  function automatic logic [31:0] image(input logic [23:0] a);
    case (a)
      24'h00_0080: return 32'h0000_0400;
      24'h00_0400: return {16'h0000, qCount};
      24'h00_0088: return 32'h0000_0030;
      24'h00_008C: return 32'h0000_1000;
      24'h00_0048: return 32'h0000_0050;
      24'h00_004C: return 32'h0000_2000;
      24'h00_0098: return 32'h0000_0070;
      default:     return {8'h20, a[7:0], 8'h20, a[7:0] + 8'h02};
    endcase
  endfunction
  // Answer at once or after a wait; data is inverted outside valid
  always @(posedge clock) begin
    memRdValid <= 1'b0;
    memRdData <= ~memRdData;
    if (memRdReq && !memRdValid) begin
      waitCnt <= waitCnt + 2'h1;
      if (!slow || waitCnt == 2'h3) begin
        memRdValid <= 1'b1;
        memRdData <= image(memAddr);
        waitCnt <= 2'h0;
      end
    end
  end
endmodule // stu_mem_model

// ### test/stu_trap_unit_sva.sv
// Concurrent checks on the software trap unit ports
`timescale 1ns/1ns
module stu_trap_unit_sva (
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        statusLoaded,
  input wire logic        svcExec,
  input wire logic        brkExec,
  input wire logic        sintExec,
  input wire logic        consoleRun,
  input wire logic        arithDone,
  input wire logic        fixedDivZero,
  input wire logic        fixedOverflow,
  input wire logic        floatDivZero,
  input wire logic        floatOverflow,
  input wire logic        floatUnderflow,
  input wire logic [63:0] currentPsw,
  input wire logic        busy,
  input wire logic        memRdReq,
  input wire logic [23:0] memAddr,
  input wire logic        regWrEn,
  input wire logic [3:0]  regWrNum,
  input wire logic        pswLoad,
  input wire logic [63:0] pswNew,
  input wire logic        consoleMode,
  input wire logic        abortInstr,
  input wire logic        zeroResult,
  input wire logic        sintStart,
  input wire logic        realAckEnable,
  input wire logic [3:0]  levelEnable
);
  // Request qualifiers
  wire logic hard = fixedDivZero | fixedOverflow | floatDivZero | floatOverflow;
  wire logic idle = !busy && !arithDone;
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // Save writes follow one another
  sequence s_r15_r13;
    regWrEn && regWrNum == stu_pkg::REG_R15 ##1 regWrEn && regWrNum == stu_pkg::REG_R13;
  endsequence
  property p_save_order; regWrEn && regWrNum == stu_pkg::REG_R14 |=> s_r15_r13; endproperty
  a_save_order: assert property (p_save_order) else $error("save order wrong");
  property p_simulate_irq_instr_levels; sintStart |-> levelEnable == 4'hF; endproperty
  a_simulate_irq_instr_levels: assert property (p_simulate_irq_instr_levels) else $error("levels not all on");
  property p_simulate_irq_instr_start; idle && sintExec && !currentPsw[stu_pkg::PSW_PROT_BIT] |=> sintStart && !realAckEnable; endproperty
  a_simulate_irq_instr_start: assert property (p_simulate_irq_instr_start) else $error("simulated start wrong");
  property p_qs_off; idle && !svcExec && statusLoaded && !currentPsw[stu_pkg::PSW_QSEN_BIT] |=> !memRdReq && !busy; endproperty
  a_qs_off: assert property (p_qs_off) else $error("queue test while off");
  property p_qs_on; idle && !svcExec && statusLoaded && currentPsw[stu_pkg::PSW_QSEN_BIT] |=> memRdReq && memAddr == stu_pkg::QUEUE_PTR_ADDR; endproperty
  a_qs_on: assert property (p_qs_on) else $error("queue pointer not read");
  property p_svc; idle && svcExec |=> memRdReq && memAddr == stu_pkg::SVC_PSW_ADDR; endproperty
  a_svc: assert property (p_svc) else $error("call not taken");
  property p_fault; !busy && arithDone && hard |=> abortInstr && memRdReq && memAddr == stu_pkg::FAULT_PSW_ADDR; endproperty
  a_fault: assert property (p_fault) else $error("fault not taken");
  property p_under; !busy && arithDone && !hard && floatUnderflow && !currentPsw[stu_pkg::PSW_UFMASK_BIT] |=> zeroResult && !abortInstr && !memRdReq; endproperty
  a_under: assert property (p_under) else $error("masked underflow wrong");
  property p_brk; idle && brkExec && !svcExec && !statusLoaded && !currentPsw[stu_pkg::PSW_PROT_BIT] |=> consoleMode && !regWrEn && !pswLoad && !memRdReq; endproperty
  a_brk: assert property (p_brk) else $error("breakpoint wrong");
  property p_console; consoleMode && consoleRun && !busy |=> !consoleMode && pswLoad && !pswNew[stu_pkg::PSW_WAIT_BIT]; endproperty
  a_console: assert property (p_console) else $error("console exit wrong");
endmodule // stu_trap_unit_sva
bind stu_trap_unit stu_trap_unit_sva u_stu_trap_unit_sva (.*);

// ### test/tb_stu_trap_unit.sv
// Self-checking bench for the software trap unit
`timescale 1ns/1ns
module tb_stu_trap_unit;
  typedef struct packed {logic [4:0] flags; logic mask; logic fault; logic [2:0] code;} stu_row_t;
  localparam int LIMIT = 3000;
  localparam stu_row_t ROWS [6] = '{'{5'h10, 1'b0, 1'b1, 3'h0}, '{5'h08, 1'b0, 1'b1, 3'h1}, '{5'h04, 1'b0, 1'b1, 3'h2},
                                    '{5'h01, 1'b1, 1'b1, 3'h3}, '{5'h02, 1'b0, 1'b1, 3'h4}, '{5'h01, 1'b0, 1'b0, 3'h0}};
  logic        clock = 1'b0, reset = 1'b1, statusLoaded = 1'b0, loadWasExchange = 1'b0, svcExec = 1'b0;
  logic        brkExec = 1'b0, sintExec = 1'b0, consoleRun = 1'b0, arithDone = 1'b0, slow = 1'b0;
  logic        fixedDivZero = 1'b0, fixedOverflow = 1'b0, floatDivZero = 1'b0, floatOverflow = 1'b0;
  logic        floatUnderflow = 1'b0, memRdValid, memRdReq, regWrEn, pswLoad, busy, consoleMode, privFault;
  logic        abortInstr, zeroResult, sintStart, realAckEnable, sawLoad = 1'b0;
  logic [3:0]  svcField = 4'h0, sintSet = 4'h0, regWrSet, regWrNum, levelEnable, sintSetOut, regSet;
  logic [9:0]  sintDevice = 10'h000, sintDeviceOut;
  logic [15:0] qCount = 16'h0000;
  logic [23:0] operandAddr = 24'h00_0000, memAddr;
  logic [31:0] nextInstrAddr = 32'h0000_0000, memRdData, regWrData, regs [16];
  logic [63:0] currentPsw = 64'h0000_0000_0000_0000, pswNew, loadedPsw;
  int          n_mismatch = 0, cmp_count = 0, cycles = 0;
  stu_trap_unit u_stu_trap_unit (.*);
  stu_mem_model u_stu_mem_model (.*);
  // Clock
  initial begin
    forever #5 clock = ~clock;
  end
  task automatic give_verdict();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Pulse one request; returns at the edge where the answer is visible
  task automatic fire(input int k);
    sawLoad <= 1'b0;
    foreach (regs[i]) regs[i] <= 32'hA5A5_A5A5;
    @(posedge clock);
    case (k)
      0: svcExec <= 1'b1;
      1: statusLoaded <= 1'b1;
      2: brkExec <= 1'b1;
      3: sintExec <= 1'b1;
      4: consoleRun <= 1'b1;
      default: arithDone <= 1'b1;
    endcase
    @(posedge clock);
    {svcExec, statusLoaded, brkExec, sintExec, consoleRun, arithDone} <= 6'h00;
    @(posedge clock);
  endtask
  task automatic waitLoad(input logic exp);
    for (int k = 0; k < 40 && !sawLoad; k++) @(posedge clock);
    chk(sawLoad, exp);
  endtask
  task automatic trapChk(input logic [3:0] s, input logic [31:0] r14, r15, input logic [63:0] p);
    chk(regSet, s);
    chk({regs[14], regs[15]}, {r14, r15});
    chk(loadedPsw, p);
  endtask
  // Register writes, status loads and the hang limit
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (regWrEn) begin
      regs[regWrNum] <= regWrData;
      regSet <= regWrSet;
    end
    if (pswLoad) begin
      sawLoad <= 1'b1;
      loadedPsw <= pswNew;
    end
    if (cycles == LIMIT) begin
      n_mismatch++;
      give_verdict();
    end
  end
  // Main sequence
  initial begin
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    repeat (2) @(posedge clock);
    chk({busy, memRdReq, regWrEn, pswLoad, consoleMode}, 5'h00);
    for (int i = 0; i < 6; i++) begin
      {fixedDivZero, fixedOverflow, floatDivZero, floatOverflow, floatUnderflow} <= ROWS[i].flags;
      currentPsw <= {ROWS[i].mask ? 32'h0000_1000 : 32'h0000_0000, 32'h0000_7000};
      nextInstrAddr <= 32'h0000_7004;
      slow <= i[0];
      fire(5);
      chk({abortInstr, zeroResult}, {ROWS[i].fault, !ROWS[i].fault});
      waitLoad(ROWS[i].fault);
      if (ROWS[i].fault) begin
        trapChk(4'h5, currentPsw[63:32], 32'h0000_7000, 64'h0000_0050_0000_2000);
        chk({regs[13], regs[12]}, {29'h0, ROWS[i].code, 32'h0000_7004});
      end
    end
    for (int n = 0; n < 2; n++) begin
      currentPsw <= 64'hFFFF_FFFF_0000_1234;
      nextInstrAddr <= 32'h0000_1238;
      operandAddr <= 24'hAB_CDEF;
      svcField <= 4'(n * 15);
      slow <= n[0];
      fire(0);
      waitLoad(1'b1);
      trapChk(4'h7, 32'hFFFF_FFFF, 32'h0000_1238, {48'h0000_0070_0000, 8'h20, 8'h9C + 8'(n * 30)});
      chk(regs[13], 32'h00AB_CDEF);
    end
    for (int c = 0; c < 4; c++) begin
      currentPsw <= {(c == 3) ? 32'h0000_0000 : 32'h0000_0200, 32'h0000_5000};
      nextInstrAddr <= 32'h0000_6000;
      loadWasExchange <= (c == 0);
      qCount <= (c == 2) ? 16'h0000 : 16'h0002;
      fire(1);
      waitLoad(c < 2);
      if (c < 2) begin
        trapChk(4'h3, 32'h0000_0200, c ? 32'h0000_5000 : 32'h0000_6000, 64'h0000_0030_0000_1000);
        chk(regs[13], 32'h0000_0400);
      end
    end
    currentPsw <= 64'h0000_0100_0000_3000;
    fire(2);
    chk({privFault, consoleMode}, 2'h2);
    currentPsw <= 64'h0000_8000_0000_3000;
    fire(2);
    chk({privFault, consoleMode}, 2'h1);
    waitLoad(1'b0);
    fire(4);
    chk({consoleMode, pswLoad}, 2'h1);
    chk(pswNew, 64'h0000_0000_0000_3000);
    currentPsw <= 64'h0000_0100_0000_3000;
    sintDevice <= 10'h3FF;
    sintSet <= 4'h2;
    fire(3);
    chk({privFault, sintStart}, 2'h2);
    currentPsw <= 64'h0000_0000_0000_3000;
    fire(3);
    chk({sintStart, realAckEnable, levelEnable}, 6'h2F);
    chk({sintDeviceOut, sintSetOut}, 14'h3FF2);
    give_verdict();
  end
endmodule // tb_stu_trap_unit
